/* core/osc_config_fuse_decode.sv */
// Oscillator configuration fuse block: fuse bank, power-on capture of the
// clock setting, code-protect gating and the register port.
// Assumes synchronous inputs, one clock and a master that never waits.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module osc_config_fuse_decode
    import osc_cfg_pkg::*;
#(
    parameter int unsigned VARIANT = VARIANT_WIDE
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output osc_setting_type osc_setting,
    output logic setting_ready,
    output logic [15:0] wdt_config,
    input wire logic outside_prog_rd_req,
    input wire logic outside_prog_wr_req,
    output logic prog_rd_grant,
    output logic prog_wr_grant,
    input wire logic firmware_active,
    input wire logic firmware_target_exec,
    output logic firmware_grant
);

    // Fuse bank wiring
    logic [CFG_WORD_COUNT-1:0][15:0] words; // Current fuse contents
    logic [CFG_WORD_COUNT-1:0] pending; // Erased, awaiting rewrite
    logic word_wr; // Write aimed at a fuse word
    logic erase_wr; // Write to the erase control
    osc_setting_type decoded; // Live decode of the stored word

    // Capture sequencer and snapshot
    capture_state_type state_reg;
    capture_state_type state_next;
    osc_setting_type setting_reg; // Held power-on setting
    osc_setting_type setting_next;
    logic [15:0] snap_reg; // Word that produced the setting
    logic [15:0] snap_next;
    logic [15:0] wdt_reg; // Held watchdog configuration
    logic [15:0] wdt_next;

    // Read path
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    // Write decode; addresses beyond the last word are not fuses
    assign word_wr = reg_wr && (reg_addr <= IDX_LAST_WORD);
    assign erase_wr = reg_wr && (reg_addr == IDX_ERASE);

    // Non-volatile words with erase tracking
    cfg_fuse_bank #(
        .WORDS(CFG_WORD_COUNT)
    ) u_bank (
        .clock(clock),
        .sys_rst(sys_rst),
        .wr_en(word_wr),
        .wr_idx(reg_addr[2:0]),
        .wr_data(reg_wdata),
        .erase_en(erase_wr),
        .erase_mask(reg_wdata[CFG_WORD_COUNT-1:0]),
        .words(words),
        .pending(pending)
    );

    // Table decode of the oscillator word
    osc_mode_decoder #(
        .VARIANT(VARIANT)
    ) u_decode (
        .cfg_word(words[IDX_OSC_WORD[2:0]]),
        .setting(decoded)
    );

    // Sequencer next state: wait one edge after release, capture, then hold.
    // Capturing a cycle late lets the bank settle out of reset first.
    always_comb begin
        state_next = state_reg;
        setting_next = setting_reg;
        snap_next = snap_reg;
        wdt_next = wdt_reg;
        unique case (state_reg)
            ST_WAIT: begin
                state_next = ST_CAPTURE;
            end
            ST_CAPTURE: begin
                // Single sample of the power-up settings
                setting_next = decoded;
                snap_next = words[IDX_OSC_WORD[2:0]];
                wdt_next = words[IDX_WDT_WORD[2:0]];
                state_next = ST_HOLD;
            end
            ST_HOLD: begin
                // Later fuse writes wait for the next power-on reset
                state_next = ST_HOLD;
            end
            default: begin
                state_next = ST_WAIT;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_WAIT;
            setting_reg <= '0;
            snap_reg <= '0;
            wdt_reg <= '0;
        end else begin
            state_reg <= state_next;
            setting_reg <= setting_next;
            snap_reg <= snap_next;
            wdt_reg <= wdt_next;
        end
    end

    // Read mux; write-only and unmapped indices read as zero
    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd) begin
            if (reg_addr <= IDX_LAST_WORD) begin
                rdata_next = words[reg_addr[2:0]];
            end else if (reg_addr == IDX_STATUS) begin
                rdata_next = pack_status(setting_reg);
            end else if (reg_addr == IDX_PENDING) begin
                rdata_next = {{(16 - CFG_WORD_COUNT){1'b0}}, pending};
            end
        end
    end

    // Read data register, valid only the cycle after the strobe
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Access gating: protection follows the live fuse, not the snapshot,
    // so protecting a part takes effect without a power cycle
    always_comb begin
        prog_rd_grant = outside_prog_rd_req && words[IDX_PROTECT_WORD[2:0]][PROT_READ_BIT];
        prog_wr_grant = outside_prog_wr_req && words[IDX_PROTECT_WORD[2:0]][PROT_WRITE_BIT];
        // Firmware fetches confined to the executive region
        firmware_grant = firmware_active && firmware_target_exec;
    end

    // Outputs
    assign reg_rdata = rdata_reg;
    assign osc_setting = setting_reg;
    assign setting_ready = (state_reg == ST_HOLD);
    assign wdt_config = wdt_reg;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Fuse port: writes land, idle cycles read back zero
    chk_word_write: assert property (word_wr |=> words[$past(reg_addr[2:0])] == $past(reg_wdata))
        else $error("fuse word did not take the written value");

    chk_unmapped_zero: assert property (reg_rd && reg_addr > IDX_PENDING |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");

    chk_read_window: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data stood outside its cycle");

    // Power-on capture copies the live decode once
    chk_capture_copy: assert property (state_reg == ST_CAPTURE |=> osc_setting == $past(decoded)
        && wdt_config == $past(words[IDX_WDT_WORD[2:0]]))
        else $error("power-on capture did not copy the decode");

    // Each protect bit blocks its own kind of outside access
    chk_protect_gate: assert property (outside_prog_rd_req && !words[IDX_PROTECT_WORD[2:0]][PROT_READ_BIT]
        |-> !prog_rd_grant)
        else $error("outside read granted while protected");

    chk_write_protect: assert property (outside_prog_wr_req && !words[IDX_PROTECT_WORD[2:0]][PROT_WRITE_BIT]
        |-> !prog_wr_grant)
        else $error("outside write granted while protected");

    // Held setting against the word it was taken from
    chk_switch_decode: assert property (setting_ready |-> osc_setting.switch_en == !snap_reg[CKSM_LSB + 1]
        && osc_setting.monitor_en == (snap_reg[CKSM_LSB +: 2] == 2'b00))
        else $error("switch or monitor decode wrong");

    chk_narrow_source: assert property (VARIANT == VARIANT_NARROW && setting_ready
        && snap_reg[SRC_LSB +: 2] == 2'b00 |-> osc_setting.source == SRC_TIMER32K)
        else $error("narrow source 00 not the timer oscillator");

    chk_reserved_invalid: assert property (VARIANT == VARIANT_WIDE && setting_ready
        && snap_reg[SRC_LSB +: 3] inside {3'b100, 3'b101, 3'b110} |-> !osc_setting.valid)
        else $error("reserved source accepted as valid");

    chk_div3_mode: assert property (VARIANT == VARIANT_WIDE && setting_ready
        && snap_reg[SRC_LSB +: 3] == 3'b111 && snap_reg[MODE_LSB +: 5] == 5'b10111
        |-> osc_setting.info.mode == MODE_HS_DIV3 && osc_setting.info.pll_log2 == 3'h4)
        else $error("divide-by-3 crystal mode decode wrong");

    chk_alt_clkout: assert property (VARIANT == VARIANT_WIDE && setting_ready
        && snap_reg[SRC_LSB +: 3] == 3'b011 && snap_reg[MODE_LSB +: 5] == 5'b01011
        |-> osc_setting.info.pin_clkout && !osc_setting.info.pin_io)
        else $error("alternate outside clock output decode wrong");

    chk_firmware_region: assert property (firmware_active && !firmware_target_exec |-> !firmware_grant)
        else $error("firmware granted outside executive region");

    // Held setting ignores later fuse writes until power-on reset
    chk_hold_stable: assert property (setting_ready |=> setting_ready && $stable(osc_setting)
        && $stable(wdt_config))
        else $error("held clock setting changed before power-on reset");

    chk_release_timing: assert property ($fell(sys_rst) |-> !setting_ready ##1 !setting_ready ##1 setting_ready)
        else $error("capture not two edges after reset release");

    // Erase flags the word; a rewrite clears the flag
    chk_erase_pending: assert property (erase_wr && reg_wdata[2] |=> pending[2]
        && words[2] == ERASED_WORD)
        else $error("erase did not flag the word for rewriting");

    chk_pending_clear: assert property (word_wr |=> !pending[$past(reg_addr[2:0])])
        else $error("rewrite left the erase flag set");

    cov_capture: cover property (state_reg == ST_CAPTURE ##1 setting_ready && osc_setting.valid);
    cov_erase_rewrite: cover property (erase_wr ##[1:4] word_wr ##1 pending == '0);
    cov_protected_read: cover property (outside_prog_rd_req && !prog_rd_grant);
    cov_invalid_setting: cover property (setting_ready && !osc_setting.valid);

endmodule : osc_config_fuse_decode
`default_nettype wire

/* core/osc_cfg_pkg.sv */
// Shared constants, types and helpers for the oscillator configuration decoder.
// Assumes one 25 MHz clock and a plain strobe-style register port.
package osc_cfg_pkg;

    // Configuration word storage
    localparam int unsigned CFG_WORD_COUNT = 7;
    localparam int unsigned CFG_WIDTH = 16;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // Register indices on the 4-bit address port
    localparam logic [3:0] IDX_OSC_WORD = 4'h0;
    localparam logic [3:0] IDX_WDT_WORD = 4'h1;
    localparam logic [3:0] IDX_PROTECT_WORD = 4'h5;
    localparam logic [3:0] IDX_LAST_WORD = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h7;
    localparam logic [3:0] IDX_ERASE = 4'h8;
    localparam logic [3:0] IDX_PENDING = 4'h9;

    // Field positions in the oscillator configuration word
    localparam int unsigned CKSM_LSB = 14;
    localparam int unsigned SRC_LSB = 8;
    localparam int unsigned MODE_LSB = 0;

    // Code-protect bits, active when cleared (erased state is unprotected)
    localparam int unsigned PROT_READ_BIT = 0;
    localparam int unsigned PROT_WRITE_BIT = 1;

    // Layout variants of the source and mode fields
    localparam int unsigned VARIANT_NARROW = 0;
    localparam int unsigned VARIANT_WIDE = 1;

    // Power-on capture sequencer states
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_CAPTURE = 3'b010,
        ST_HOLD = 3'b100
    } capture_state_type;

    // Chosen oscillator source
    typedef enum logic [2:0] {
        SRC_PRIMARY = 3'h0,
        SRC_LP_RC = 3'h1,
        SRC_FAST_RC = 3'h2,
        SRC_TIMER32K = 3'h3,
        SRC_ALTERNATE = 3'h4,
        SRC_INVALID = 3'h7
    } source_type;

    // Chosen primary or alternate oscillator mode
    typedef enum logic [3:0] {
        MODE_NONE = 4'h0,
        MODE_OUTSIDE_CLOCK_IO = 4'h1,
        MODE_OUTSIDE_CLOCK_CLKOUT = 4'h2,
        MODE_OUTSIDE_RC_CLKOUT = 4'h3,
        MODE_OUTSIDE_RC_IO = 4'h4,
        MODE_MID_FREQ_CRYSTAL = 4'h5,
        MODE_HIGH_SPEED_CRYSTAL = 4'h6,
        MODE_LOW_FREQ_CRYSTAL = 4'h7,
        MODE_HS_DIV3 = 4'h8,
        MODE_HS_DIV2 = 4'h9,
        MODE_RESERVED = 4'hF
    } mode_type;

    // Mode plus multiplier and output pin use
    typedef struct packed {
        mode_type mode;
        logic [2:0] pll_log2;
        logic pin_io;
        logic pin_clkout;
    } mode_info_type;

    // Complete decoded clock setting
    typedef struct packed {
        logic valid;
        logic switch_en;
        logic monitor_en;
        source_type source;
        mode_info_type info;
    } osc_setting_type;

    // Builds one mode entry in a single line of a decode table
    function automatic mode_info_type mode_info(input mode_type m, input logic [2:0] p,
                                                input logic io, input logic ck);
        mode_info_type r;
        r.mode = m;
        r.pll_log2 = p;
        r.pin_io = io;
        r.pin_clkout = ck;
        return r;
    endfunction : mode_info

    // Status word: [15] valid, [14] switch, [13] monitor, [12:10] source,
    // [9:6] mode, [5:3] multiplier log2, [2] pin io, [1] pin clock out
    function automatic logic [15:0] pack_status(input osc_setting_type s);
        return {s.valid, s.switch_en, s.monitor_en, s.source, s.info, 1'b0};
    endfunction : pack_status

endpackage : osc_cfg_pkg

/* core/cfg_fuse_bank.sv */
// Bank of non-volatile configuration words with per-word erase.
// Assumes the register port never writes and erases in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cfg_fuse_bank
    import osc_cfg_pkg::*;
#(
    parameter int unsigned WORDS = CFG_WORD_COUNT
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic erase_en,
    input wire logic [WORDS-1:0] erase_mask,
    output logic [WORDS-1:0][15:0] words,
    output logic [WORDS-1:0] pending
);

    logic [WORDS-1:0][15:0] words_reg; // Stored fuse values
    logic [WORDS-1:0][15:0] words_next;
    logic [WORDS-1:0] pending_reg; // Erased and not yet rewritten
    logic [WORDS-1:0] pending_next;

    // Next values: an erase sets the word to ones and flags it for rewriting
    always_comb begin
        words_next = words_reg;
        pending_next = pending_reg;
        for (int i = 0; i < WORDS; i++) begin
            if (wr_en && wr_idx == i[2:0]) begin
                words_next[i] = wr_data;
                pending_next[i] = 1'b0; // Rewrite satisfies the erase
            end
            // Erase after the write so a flag raised now is never lost
            if (erase_en && erase_mask[i]) begin
                words_next[i] = ERASED_WORD;
                pending_next[i] = 1'b1;
            end
        end
    end

    // Registers; reset loads the erased state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            words_reg <= {WORDS{ERASED_WORD}};
            pending_reg <= '0;
        end else begin
            words_reg <= words_next;
            pending_reg <= pending_next;
        end
    end

    assign words = words_reg;
    assign pending = pending_reg;

endmodule : cfg_fuse_bank
`default_nettype wire

/* core/osc_mode_decoder.sv */
// Pure decode of the oscillator configuration word into a clock setting.
// Assumes the caller samples the result at the right moment.
`timescale 1ns/1ps
`default_nettype none
module osc_mode_decoder
    import osc_cfg_pkg::*;
#(
    parameter int unsigned VARIANT = VARIANT_WIDE
) (
    input wire logic [15:0] cfg_word,
    output osc_setting_type setting
);

    logic [1:0] clk_switch_monitor_sel; // Switch and monitor field
    logic [2:0] osc_source_sel; // Source field
    logic [4:0] osc_mode_sel; // Mode field

    // Field extraction, then table lookups
    always_comb begin
        clk_switch_monitor_sel = cfg_word[CKSM_LSB +: 2];
        osc_source_sel = cfg_word[SRC_LSB +: 3];
        osc_mode_sel = cfg_word[MODE_LSB +: 5];
        setting.switch_en = (clk_switch_monitor_sel[1] == 1'b0);
        setting.monitor_en = (clk_switch_monitor_sel == 2'b00);
        // Source selection
        if (VARIANT == VARIANT_NARROW) begin
            unique case (osc_source_sel[1:0])
                2'b11: setting.source = SRC_PRIMARY;
                2'b10: setting.source = SRC_LP_RC;
                2'b01: setting.source = SRC_FAST_RC;
                2'b00: setting.source = SRC_TIMER32K;
            endcase
        end else begin
            case (osc_source_sel)
                3'b111: setting.source = SRC_PRIMARY;
                3'b011: setting.source = SRC_ALTERNATE;
                3'b010: setting.source = SRC_LP_RC;
                3'b001: setting.source = SRC_FAST_RC;
                3'b000: setting.source = SRC_TIMER32K;
                default: setting.source = SRC_INVALID; // Reserved codes
            endcase
        end
        // Mode selection, only meaningful for primary or alternate
        setting.info = mode_info(MODE_NONE, 3'h0, 1'b0, 1'b0);
        if (setting.source == SRC_PRIMARY && VARIANT == VARIANT_NARROW) begin
            casez (osc_mode_sel[3:0])
                4'b1111: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h4, 1'b1, 1'b0);
                4'b1110: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h3, 1'b1, 1'b0);
                4'b1101: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h2, 1'b1, 1'b0);
                4'b1100: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h0, 1'b1, 1'b0);
                4'b1011: setting.info = mode_info(MODE_OUTSIDE_CLOCK_CLKOUT, 3'h0, 1'b0, 1'b1);
                4'b1001: setting.info = mode_info(MODE_OUTSIDE_RC_CLKOUT, 3'h0, 1'b0, 1'b1);
                4'b1000: setting.info = mode_info(MODE_OUTSIDE_RC_IO, 3'h0, 1'b1, 1'b0);
                4'b0111: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h4, 1'b0, 1'b0);
                4'b0110: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h3, 1'b0, 1'b0);
                4'b0101: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h2, 1'b0, 1'b0);
                4'b0100: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h0, 1'b0, 1'b0);
                4'b001?: setting.info = mode_info(MODE_HIGH_SPEED_CRYSTAL, 3'h0, 1'b0, 1'b0);
                4'b0000: setting.info = mode_info(MODE_LOW_FREQ_CRYSTAL, 3'h0, 1'b0, 1'b0);
                default: setting.info = mode_info(MODE_RESERVED, 3'h0, 1'b0, 1'b0);
            endcase
        end else if (setting.source == SRC_PRIMARY) begin
            case (osc_mode_sel)
                5'b10111: setting.info = mode_info(MODE_HS_DIV3, 3'h4, 1'b0, 1'b0);
                5'b10110: setting.info = mode_info(MODE_HS_DIV3, 3'h3, 1'b0, 1'b0);
                5'b10101: setting.info = mode_info(MODE_HS_DIV3, 3'h2, 1'b0, 1'b0);
                5'b10011: setting.info = mode_info(MODE_HS_DIV2, 3'h4, 1'b0, 1'b0);
                5'b10010: setting.info = mode_info(MODE_HS_DIV2, 3'h3, 1'b0, 1'b0);
                5'b10001: setting.info = mode_info(MODE_HS_DIV2, 3'h2, 1'b0, 1'b0);
                5'b01111: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h4, 1'b1, 1'b0);
                5'b01110: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h3, 1'b1, 1'b0);
                5'b01101: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h2, 1'b1, 1'b0);
                5'b00111: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h4, 1'b0, 1'b0);
                5'b00110: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h3, 1'b0, 1'b0);
                5'b00101: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h2, 1'b0, 1'b0);
                default: setting.info = mode_info(MODE_RESERVED, 3'h0, 1'b0, 1'b0); // 11xxx too
            endcase
        end else if (setting.source == SRC_ALTERNATE) begin
            case (osc_mode_sel)
                5'b01100: setting.info = mode_info(MODE_OUTSIDE_CLOCK_IO, 3'h0, 1'b1, 1'b0);
                5'b01011: setting.info = mode_info(MODE_OUTSIDE_CLOCK_CLKOUT, 3'h0, 1'b0, 1'b1);
                5'b01001: setting.info = mode_info(MODE_OUTSIDE_RC_CLKOUT, 3'h0, 1'b0, 1'b1);
                5'b01000: setting.info = mode_info(MODE_OUTSIDE_RC_IO, 3'h0, 1'b1, 1'b0);
                5'b00100: setting.info = mode_info(MODE_MID_FREQ_CRYSTAL, 3'h0, 1'b0, 1'b0);
                5'b00010: setting.info = mode_info(MODE_HIGH_SPEED_CRYSTAL, 3'h0, 1'b0, 1'b0);
                5'b00000: setting.info = mode_info(MODE_LOW_FREQ_CRYSTAL, 3'h0, 1'b0, 1'b0);
                default: setting.info = mode_info(MODE_RESERVED, 3'h0, 1'b0, 1'b0);
            endcase
        end
        // Reserved source or mode marks the whole setting invalid
        setting.valid = (setting.source != SRC_INVALID) && (setting.info.mode != MODE_RESERVED);
    end

endmodule : osc_mode_decoder
`default_nettype wire

/* verification/fuse_programmer_model.sv */
// Programmer model that drives the fuse block's register port.
// Assumes it launches strobes right after a rising edge and reads data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module fuse_programmer_model
    import osc_cfg_pkg::*;
(
    input wire logic clock,
    output logic [3:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    // Idle bus at time zero
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; the data lines are inverted afterwards so stale data is never reused
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // One-cycle read; the data stand only in the following cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Erase, then rewrite even an all-ones value, then read back
    task automatic burn(input logic [2:0] i, input logic [15:0] d, output logic [15:0] q);
        wr(IDX_ERASE, 16'h0001 << i);
        wr({1'b0, i}, d);
        rd({1'b0, i}, q);
    endtask : burn
endmodule : fuse_programmer_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the oscillator configuration fuse block.
// Assumes a 25 MHz clock and power-on capture at the second edge after reset release.
`timescale 1ns/1ps
`default_nettype none
module tb_top import osc_cfg_pkg::*;;
    localparam logic [14:0] NOPIN = 15'h7FFC;
    localparam logic [14:0] ALLB = 15'h7FFF;
    localparam logic [14:0] VONLY = 15'h4000;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, wdt_config, q;
    logic reg_wr, reg_rd, setting_ready, prog_rd_grant, prog_wr_grant, firmware_grant;
    logic outside_prog_rd_req = 1'b0;
    logic outside_prog_wr_req = 1'b0;
    logic firmware_active = 1'b0;
    logic firmware_target_exec = 1'b0;
    osc_setting_type osc_setting;
    osc_setting_type narrow_setting; // Same block built for the two-bit source layout
    int mismatches = 0;
    int check_count = 0;
    // 40 ns period
    always #20 clock = ~clock;
    osc_config_fuse_decode u_osc_config_fuse_decode (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_setting(osc_setting),
        .setting_ready(setting_ready), .wdt_config(wdt_config), .outside_prog_rd_req(outside_prog_rd_req),
        .outside_prog_wr_req(outside_prog_wr_req), .prog_rd_grant(prog_rd_grant), .prog_wr_grant(prog_wr_grant),
        .firmware_active(firmware_active), .firmware_target_exec(firmware_target_exec),
        .firmware_grant(firmware_grant));
    osc_config_fuse_decode #(.VARIANT(VARIANT_NARROW)) u_osc_config_fuse_decode_narrow (.clock(clock),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .osc_setting(narrow_setting), .setting_ready(), .wdt_config(),
        .outside_prog_rd_req(outside_prog_rd_req), .outside_prog_wr_req(outside_prog_wr_req), .prog_rd_grant(),
        .prog_wr_grant(), .firmware_active(firmware_active), .firmware_target_exec(firmware_target_exec),
        .firmware_grant());
    fuse_programmer_model prog (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [14:0] e(input logic v, sw, mo, input source_type s, input mode_type m,
        input logic [2:0] p, input logic [1:0] pins);
        return {v, sw, mo, s, m, p, pins};
    endfunction : e
    // Reset, then store the word at the first edge after release so the capture sees it
    task automatic por_case(input logic [15:0] w, input logic [14:0] x, input logic [14:0] m);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (20) @(posedge clock);
        fork
            begin
                @(posedge clock);
                sys_rst <= 1'b0;
            end
            prog.wr(IDX_OSC_WORD, w);
        join
        #1 check({15'h0, setting_ready}, 16'h0000);
        @(posedge clock);
        #1 check({1'b0, osc_setting & m}, {1'b0, x & m});
        check({15'h0, setting_ready}, 16'h0001);
    endtask : por_case
    task automatic tally_and_finish;
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // Hang guard
    initial begin
        #2000000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        por_case(16'h0717, e(1, 1, 1, SRC_PRIMARY, MODE_HS_DIV3, 3'h4, 2'b00), NOPIN);
        check({1'b0, narrow_setting}, {1'b0, e(1, 1, 1, SRC_PRIMARY, MODE_MID_FREQ_CRYSTAL, 3'h4, 2'b00)});
        por_case(16'h4713, e(1, 1, 0, SRC_PRIMARY, MODE_HS_DIV2, 3'h4, 2'b00), NOPIN);
        por_case(16'h830B, e(1, 0, 0, SRC_ALTERNATE, MODE_OUTSIDE_CLOCK_CLKOUT, 3'h0, 2'b01), ALLB);
        por_case(16'hC30C, e(1, 0, 0, SRC_ALTERNATE, MODE_OUTSIDE_CLOCK_IO, 3'h0, 2'b10), ALLB);
        por_case(16'hC304, e(1, 0, 0, SRC_ALTERNATE, MODE_MID_FREQ_CRYSTAL, 3'h0, 2'b00), NOPIN);
        por_case(16'hC302, e(1, 0, 0, SRC_ALTERNATE, MODE_HIGH_SPEED_CRYSTAL, 3'h0, 2'b00), NOPIN);
        por_case(16'hC300, e(1, 0, 0, SRC_ALTERNATE, MODE_LOW_FREQ_CRYSTAL, 3'h0, 2'b00), NOPIN);
        por_case(16'hC309, e(1, 0, 0, SRC_ALTERNATE, MODE_OUTSIDE_RC_CLKOUT, 3'h0, 2'b01), ALLB);
        por_case(16'hC308, e(1, 0, 0, SRC_ALTERNATE, MODE_OUTSIDE_RC_IO, 3'h0, 2'b10), ALLB);
        por_case(16'hC200, e(1, 0, 0, SRC_LP_RC, MODE_NONE, 3'h0, 2'b00), NOPIN);
        por_case(16'hC100, e(1, 0, 0, SRC_FAST_RC, MODE_NONE, 3'h0, 2'b00), NOPIN);
        por_case(16'hC000, e(1, 0, 0, SRC_TIMER32K, MODE_NONE, 3'h0, 2'b00), NOPIN);
        check({1'b0, narrow_setting}, {1'b0, e(1, 0, 0, SRC_TIMER32K, MODE_NONE, 3'h0, 2'b00)});
        por_case(16'hC718, 15'h0000, VONLY);
        por_case(16'hC500, 15'h0000, VONLY);
        check(wdt_config, 16'hFFFF);
        // Later fuse writes leave the held setting alone
        prog.wr(IDX_OSC_WORD, 16'hC000);
        #1 check({1'b0, osc_setting & VONLY}, 16'h0000);
        prog.burn(3'h2, 16'hA5C3, q);
        check(q, 16'hA5C3);
        prog.wr(IDX_ERASE, 16'h0008);
        prog.rd(IDX_PENDING, q);
        check(q, 16'h0008);
        prog.rd(4'h3, q);
        check(q, 16'hFFFF);
        prog.rd(4'hC, q);
        check(q, 16'h0000);
        // Read protection only, then write protection only
        prog.wr(IDX_PROTECT_WORD, 16'hFFFE);
        outside_prog_rd_req <= 1'b1;
        outside_prog_wr_req <= 1'b1;
        #1 check({14'h0, prog_rd_grant, prog_wr_grant}, 16'h0001);
        prog.wr(IDX_PROTECT_WORD, 16'hFFFD);
        #1 check({14'h0, prog_rd_grant, prog_wr_grant}, 16'h0002);
        // Firmware taken as resident, so not reloaded; no data RAM is relied on after it
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {firmware_active, firmware_target_exec} <= 2'(i);
            #1 check({15'h0, firmware_grant}, {15'h0, i == 3});
        end
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
